/* design/ao_pkg.sv */
package ao_pkg;

   // fifo geometry
   localparam int FIFO_DEPTH = 4096;
   localparam int FIFO_AW = 12;
   localparam int CNT_W = 13;
   localparam int SAMPLE_W = 16;
   localparam int WORD_W = 32;

   // field positions inside one packed host word
   localparam int EVEN_LSB = 0;
   localparam int ODD_LSB = 16;

   // reset values
   localparam logic [SAMPLE_W-1:0] DAC_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
   localparam logic [FIFO_AW-1:0] PTR_ZERO = 12'h000;
   localparam logic [FIFO_AW-1:0] PTR_ONE = 12'h001;

   // operating modes
   typedef enum logic [1:0]
   {
      MODE_STREAM = 2'h0,
      MODE_WAVE = 2'h1
   } mode_t;

   // packed host transfer
   typedef struct packed
   {
      logic [SAMPLE_W-1:0] odd;
      logic [SAMPLE_W-1:0] even;
   } pair_t;

   // converter output pair
   typedef struct packed
   {
      logic [SAMPLE_W-1:0] dac1;
      logic [SAMPLE_W-1:0] dac0;
   } dac_out_t;

endpackage

/* design/ao_sample_fifo.sv */
`timescale 1ns/1ps
// sample store with count and waveform replay pointer rewind
module ao_sample_fifo #(
   parameter int DEPTH = ao_pkg::FIFO_DEPTH,
   parameter int AW = ao_pkg::FIFO_AW,
   parameter int CW = ao_pkg::CNT_W,
   parameter int DW = ao_pkg::SAMPLE_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic wr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic rd_i,
   input wire logic rewind_i,
   output logic [DW-1:0] rd_data_o,
   output logic [CW-1:0] count_o,
   output logic [CW-1:0] loaded_o
);

   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] loaded_r;

   assign rd_data_o = mem[rptr_r];
   assign count_o = count_r;
   assign loaded_o = loaded_r;

   ////////////////////////////////////////////////////////////////////////////////
   // storage array, no reset so it maps to ram
   always_ff @(posedge clk_i)
   begin
      if (wr_i)
         mem[wptr_r] <= wr_data_i;
   end

   // write pointer and total loaded since clear, kept for replay
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wptr_r <= ao_pkg::PTR_ZERO;
         loaded_r <= ao_pkg::CNT_ZERO;
      end
      else if (clear_i)
      begin
         wptr_r <= ao_pkg::PTR_ZERO;
         loaded_r <= ao_pkg::CNT_ZERO;
      end
      else if (wr_i)
      begin
         wptr_r <= wptr_r + ao_pkg::PTR_ONE;
         loaded_r <= loaded_r + ao_pkg::CNT_ONE;
      end
   end

   // read pointer; rewind restarts the stored pattern
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rptr_r <= ao_pkg::PTR_ZERO;
      else if (clear_i || rewind_i)
         rptr_r <= ao_pkg::PTR_ZERO;
      else if (rd_i)
         rptr_r <= rptr_r + ao_pkg::PTR_ONE;
   end

   // fill count: up on load, down on read, rewind refills to loaded total
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         count_r <= ao_pkg::CNT_ZERO;
      else if (clear_i)
         count_r <= ao_pkg::CNT_ZERO;
      else if (rewind_i)
         count_r <= loaded_r;
      else if (wr_i && !rd_i)
         count_r <= count_r + ao_pkg::CNT_ONE;
      else if (rd_i && !wr_i)
         count_r <= count_r - ao_pkg::CNT_ONE;
   end

endmodule

/* design/analog_output_fifo_sequencer.sv */
`timescale 1ns/1ps
// Overview of operation
// - even half of each transfer enters the fifo before the odd half
// - with two converters even samples go to entry 0, odd to entry 1
// - with one converter every sample goes to it, even and odd alternating
// - stream mode drains queued host data and stops once none is left
// - waveform mode replays stored fifo contents until stopped, no new transfers
// - an underflow error flag is visible to the host
// - clock tick on empty fifo flags nothing; converters hold last value
// - data written after an empty tick is output and raises underflow
// - underflow never changes output behaviour; host can clear it
// - host can read the number of samples held in the fifo
// - after underflow converters keep the last data received
// - fifo holds up to 4096 samples; host writes stop once the count exceeds 4092
// - counter counts up on load, down on read, zero on fifo reset
// - pattern 2..4096 single or 2..2048 dual; rewind fifo when it empties
module analog_output_fifo_sequencer #(
   parameter int DEPTH = ao_pkg::FIFO_DEPTH,
   parameter int AW = ao_pkg::FIFO_AW,
   parameter int CW = ao_pkg::CNT_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ao_pkg::WORD_W-1:0] host_data_i,
   input wire logic host_wr_i,
   input wire logic fifo_reset_i,
   input wire logic run_i,
   input wire logic wave_mode_i,
   input wire logic dual_dac_i,
   input wire logic dac_tick_i,
   input wire logic err_clear_i,
   output logic host_ready_o,
   output logic [ao_pkg::SAMPLE_W-1:0] dac0_o,
   output logic [ao_pkg::SAMPLE_W-1:0] dac1_o,
   output logic dac0_load_o,
   output logic dac1_load_o,
   output logic underflow_o,
   output logic [CW-1:0] fifo_count_o,
   output logic active_o
);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_EVEN = 3'b010,
      ST_ODD = 3'b100
   } wr_state_t;

   wr_state_t wr_state_r;
   ao_pkg::pair_t pair_r;
   ao_pkg::mode_t mode_r;
   ao_pkg::dac_out_t dac_r;
   logic fifo_wr;
   logic [ao_pkg::SAMPLE_W-1:0] fifo_wdata;
   logic fifo_rd;
   logic rewind;
   logic [ao_pkg::SAMPLE_W-1:0] fifo_rdata;
   logic [CW-1:0] count;
   logic [CW-1:0] loaded;
   logic fifo_empty;
   logic starved_r;
   logic odd_slot_r;
   logic underflow_r;
   logic dac0_load_r;
   logic dac1_load_r;
   logic ready_r;
   logic active_r;
   logic [CW-1:0] count_r;
   logic tick_consume;
   logic dual_second;

   // room for a full pair after any write already in flight
   function automatic logic has_room(input logic [CW-1:0] c);
      return (c <= CW'(DEPTH - 4));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // fifo instance

   ao_sample_fifo #(
      .DEPTH(DEPTH),
      .AW(AW),
      .CW(CW),
      .DW(ao_pkg::SAMPLE_W)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(fifo_reset_i),
      .wr_i(fifo_wr),
      .wr_data_i(fifo_wdata),
      .rd_i(fifo_rd),
      .rewind_i(rewind),
      .rd_data_o(fifo_rdata),
      .count_o(count),
      .loaded_o(loaded)
   );

   assign fifo_empty = (count == ao_pkg::CNT_ZERO);

   ////////////////////////////////////////////////////////////////////////////////
   // host write path: each word splits into two fifo entries

   // latch the pair; host is held off by ready so nothing is dropped
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         pair_r <= '0;
      else if (host_wr_i && ready_r && wr_state_r == ST_IDLE)
         pair_r <= ao_pkg::pair_t'(host_data_i);
   end

   // two-step sequencer, even half always first
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wr_state_r <= ST_IDLE;
      else if (fifo_reset_i)
         wr_state_r <= ST_IDLE;
      else
      begin
         unique case (wr_state_r)
            ST_IDLE:
               if (host_wr_i && ready_r)
                  wr_state_r <= ST_EVEN;
            ST_EVEN:
               wr_state_r <= ST_ODD;
            ST_ODD:
               wr_state_r <= ST_IDLE;
            default:
               wr_state_r <= ST_IDLE;
         endcase
      end
   end

   // waveform mode takes data running or stopped, replay needs no bus traffic
   assign fifo_wr = (wr_state_r == ST_EVEN) || (wr_state_r == ST_ODD);
   assign fifo_wdata = (wr_state_r == ST_ODD) ? pair_r.odd : pair_r.even;

   // ready registered; one cycle slack covered by the margin in has_room
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ready_r <= 1'b0;
      else
         ready_r <= has_room(count) && (wr_state_r == ST_IDLE) && !fifo_reset_i
                    && !(host_wr_i && ready_r);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // converter side

   // mode is sampled while stopped so it cannot change mid run
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         mode_r <= ao_pkg::MODE_STREAM;
      else if (!run_i)
         mode_r <= wave_mode_i ? ao_pkg::MODE_WAVE : ao_pkg::MODE_STREAM;
   end

   // a tick reads one sample, in dual mode two (even then odd)
   assign tick_consume = run_i && dac_tick_i && !fifo_empty && !fifo_wr;
   assign dual_second = dual_dac_i && odd_slot_r;
   assign fifo_rd = tick_consume || (run_i && dual_second && !fifo_empty && !fifo_wr);
   // rewind when drained in waveform mode; pattern must be at least two
   assign rewind = run_i && (mode_r == ao_pkg::MODE_WAVE) && fifo_empty
                   && (loaded > CW'(1)) && !fifo_wr;

   // parity of next sample and dual-mode second read pending
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         odd_slot_r <= 1'b0;
      else if (fifo_reset_i || !run_i || rewind)
         odd_slot_r <= 1'b0;
      else if (fifo_rd)
         odd_slot_r <= !odd_slot_r;
   end

   // output registers hold last value while fifo is empty
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         dac_r <= {ao_pkg::DAC_RESET, ao_pkg::DAC_RESET};
      else if (fifo_rd)
      begin
         if (dual_dac_i && odd_slot_r)
            dac_r.dac1 <= fifo_rdata;
         else
            dac_r.dac0 <= fifo_rdata;
      end
   end

   // load strobes mark a fresh converter value
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dac0_load_r <= 1'b0;
         dac1_load_r <= 1'b0;
      end
      else
      begin
         dac0_load_r <= fifo_rd && !(dual_dac_i && odd_slot_r);
         dac1_load_r <= fifo_rd && dual_dac_i && odd_slot_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // underflow tracking; purely a flag, never gates the data path

   // a tick that found the stream fifo empty arms the detector silently
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         starved_r <= 1'b0;
      else if (fifo_reset_i || !run_i)
         starved_r <= 1'b0;
      else if (dac_tick_i && fifo_empty && mode_r == ao_pkg::MODE_STREAM)
         starved_r <= 1'b1;
      else if (host_wr_i && ready_r)
         starved_r <= 1'b0;
   end

   // sticky flag, a new event beats a simultaneous clear
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         underflow_r <= 1'b0;
      else if (starved_r && host_wr_i && ready_r)
         underflow_r <= 1'b1;
      else if (err_clear_i)
         underflow_r <= 1'b0;
   end

   // stream run is active while data remains; ends when host queue runs dry
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         active_r <= 1'b0;
      else
         active_r <= run_i && (!fifo_empty || (mode_r == ao_pkg::MODE_WAVE));
   end

   // registered copy of the fill counter for the host
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         count_r <= ao_pkg::CNT_ZERO;
      else
         count_r <= count;
   end

   assign host_ready_o = ready_r;
   assign dac0_o = dac_r.dac0;
   assign dac1_o = dac_r.dac1;
   assign dac0_load_o = dac0_load_r;
   assign dac1_load_o = dac1_load_r;
   assign underflow_o = underflow_r;
   assign fifo_count_o = count_r;
   assign active_o = active_r;

endmodule

/* verif/ao_seq_chk.sv */
`timescale 1ns/1ps
module ao_seq_chk #(
   parameter int DEPTH = 4096,
   parameter int CW = 13
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic host_wr_i,
   input wire logic host_ready_o,
   input wire logic fifo_reset_i,
   input wire logic run_i,
   input wire logic wave_mode_i,
   input wire logic dual_dac_i,
   input wire logic err_clear_i,
   input wire logic [ao_pkg::SAMPLE_W-1:0] dac0_o,
   input wire logic [ao_pkg::SAMPLE_W-1:0] dac1_o,
   input wire logic dac0_load_o,
   input wire logic dac1_load_o,
   input wire logic underflow_o,
   input wire logic [CW-1:0] fifo_count_o,
   input wire logic active_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   // the take and the two half writes hold ready low, so the writer waits three cycles
   a_ready_gap: assert property (host_wr_i && host_ready_o |=> !host_ready_o [*3])
      else $error("ready back too soon");
   a_dac0_hold: assert property (!dac0_load_o |-> $stable(dac0_o))
      else $error("dac0 moved without load");
   a_dac1_hold: assert property (!dac1_load_o |-> $stable(dac1_o))
      else $error("dac1 moved without load");
   a_single_dac: assert property ((!dual_dac_i) [*3] |-> !dac1_load_o)
      else $error("dac1 loaded in single mode");
   a_uf_cause: assert property ($rose(underflow_o) |-> $past(host_wr_i && host_ready_o))
      else $error("underflow without a write");
   a_uf_sticky: assert property (underflow_o && !err_clear_i |=> underflow_o)
      else $error("underflow dropped by itself");
   a_uf_clear: assert property (err_clear_i && !(host_wr_i && host_ready_o) |=> !underflow_o)
      else $error("underflow not cleared");
   a_wave_quiet: assert property (run_i && wave_mode_i && !underflow_o |=> !underflow_o)
      else $error("underflow in waveform mode");
   a_count_cap: assert property (fifo_count_o <= DEPTH)
      else $error("count above depth");
   a_count_clr: assert property (fifo_reset_i && !host_wr_i |=> ##1 fifo_count_o == '0)
      else $error("count not cleared");
   a_stop_idle: assert property (!run_i |=> !active_o)
      else $error("active while stopped");
   c_underflow: cover property ($rose(underflow_o));
   c_dual: cover property (dac1_load_o);
   c_wave: cover property (wave_mode_i && active_o && dac0_load_o);
endmodule
bind analog_output_fifo_sequencer ao_seq_chk #(.DEPTH(DEPTH), .CW(CW)) ao_seq_chk_i (
   .clk_i, .rst_i, .host_wr_i, .host_ready_o, .fifo_reset_i, .run_i, .wave_mode_i,
   .dual_dac_i, .err_clear_i, .dac0_o, .dac1_o, .dac0_load_o, .dac1_load_o,
   .underflow_o, .fifo_count_o, .active_o);

/* verif/ao_host_model.sv */
`timescale 1ns/1ps
module ao_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic host_ready_o,
   output logic host_wr_o,
   output logic [ao_pkg::WORD_W-1:0] host_data_o
);
   logic [ao_pkg::WORD_W-1:0] q[$];
   initial
   begin
      host_wr_o = 1'b0;
      host_data_o = '0;
   end
   // queued words offered whole, held until the edge that takes them
   always @(posedge clk_i)
   begin
      if (host_wr_o && host_ready_o && !rst_i)
         void'(q.pop_front());
      #1;
      if (rst_i || q.size() == 0)
      begin
         host_wr_o <= 1'b0;
         host_data_o <= ~host_data_o; // idle bus keeps moving
      end
      else
      begin
         host_wr_o <= 1'b1;
         host_data_o <= q[0];
      end
   end
endmodule

/* verif/analog_output_fifo_sequencer_tb.sv */
`timescale 1ns/1ps
module analog_output_fifo_sequencer_tb;
   typedef struct packed
   {
      logic dual;
      logic [31:0] w;
      logic [15:0] e0;
      logic [15:0] e1;
   } row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic fifo_reset_i = 1'b0;
   logic run_i = 1'b0;
   logic wave_mode_i = 1'b0;
   logic dual_dac_i = 1'b0;
   logic dac_tick_i = 1'b0;
   logic err_clear_i = 1'b0;
   logic host_wr_i;
   logic host_ready_o;
   logic dac0_load_o;
   logic dac1_load_o;
   logic underflow_o;
   logic active_o;
   logic [31:0] host_data_i;
   logic [15:0] dac0_o;
   logic [15:0] dac1_o;
   logic [12:0] fifo_count_o;
   int err_count = 0;
   int n_checks = 0;
   int j;
   // full-scale ends of offset binary in the first row
   row_t rows [4] = '{
      '{1'b1, 32'hFFFF_0000, 16'h0000, 16'hFFFF},
      '{1'b1, 32'h1234_ABCD, 16'hABCD, 16'h1234},
      '{1'b0, 32'h8000_7FFF, 16'h7FFF, 16'h8000},
      '{1'b0, 32'h0001_FFFE, 16'hFFFE, 16'h0001}
   };
   initial forever #12.5 clk_i = ~clk_i;
   analog_output_fifo_sequencer analog_output_fifo_sequencer_i (
      .clk_i, .rst_i, .host_data_i, .host_wr_i, .fifo_reset_i, .run_i, .wave_mode_i,
      .dual_dac_i, .dac_tick_i, .err_clear_i, .host_ready_o, .dac0_o, .dac1_o,
      .dac0_load_o, .dac1_load_o, .underflow_o, .fifo_count_o, .active_o);
   ao_host_model ao_host_model_i (.clk_i, .rst_i, .host_ready_o,
      .host_wr_o(host_wr_i), .host_data_o(host_data_i));
   ////////////////////////////////////////
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask
   // stimulus from this block lands 2 ns after the edge; the host model drives 1 ns after it
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   task automatic tick();
      dac_tick_i = 1'b1;
      cyc(1);
      dac_tick_i = 1'b0;
      cyc(3);
   endtask
   // count output trails the take by three edges
   task automatic load(input logic [31:0] w);
      ao_host_model_i.q.push_back(w);
      for (int i = 0; i < 20 && ao_host_model_i.q.size() > 0; i++)
         cyc(1);
      // a word never taken counts as a mismatch, not a silent skip
      chk_bit(ao_host_model_i.q.size() == 0, 1'b1);
      cyc(4);
   endtask
   task automatic start(input logic dual, input logic wave);
      run_i = 1'b0;
      cyc(1);
      dual_dac_i = dual;
      wave_mode_i = wave;
      fifo_reset_i = 1'b1;
      cyc(1);
      fifo_reset_i = 1'b0;
      cyc(1);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      cyc(6);
      rst_i = 1'b0;
      cyc(1);
      chk_val(dac0_o, ao_pkg::DAC_RESET);
      chk_val(16'(fifo_count_o), 16'h0000);
      $display("reset test done");
      foreach (rows[k])
      begin
         start(rows[k].dual, 1'b0);
         run_i = 1'b1;
         load(rows[k].w);
         chk_val(16'(fifo_count_o), 16'h0002);
         tick();
         chk_val(dac0_o, rows[k].e0);
         if (!rows[k].dual)
            tick();
         chk_val(rows[k].dual ? dac1_o : dac0_o, rows[k].e1);
         chk_val(16'(fifo_count_o), 16'h0000);
         chk_bit(active_o, 1'b0);
      end
      $display("row tests done");
      // empty tick is silent, the late write is not
      tick();
      chk_bit(underflow_o, 1'b0);
      chk_val(dac0_o, 16'h0001);
      load(32'h5555_AAAA);
      chk_bit(underflow_o, 1'b1);
      tick();
      chk_val(dac0_o, 16'hAAAA);
      cyc(5);
      chk_bit(underflow_o, 1'b1);
      err_clear_i = 1'b1;
      cyc(1);
      err_clear_i = 1'b0;
      cyc(1);
      chk_bit(underflow_o, 1'b0);
      $display("underflow test done");
      // four-sample pattern must wrap without new writes
      start(1'b0, 1'b1);
      load(32'h2222_1111);
      load(32'h4444_3333);
      run_i = 1'b1;
      cyc(1);
      for (j = 0; j < 6; j++)
      begin
         tick();
         chk_val(dac0_o, 16'(16'h1111 * (j % 4 + 1)));
      end
      chk_bit(underflow_o, 1'b0);
      chk_bit(active_o, 1'b1);
      run_i = 1'b0;
      cyc(2);
      chk_bit(active_o, 1'b0);
      $display("waveform test done");
      results();
   end
   initial
   begin
      #50000;
      err_count++;
      results();
   end
endmodule
